/* File: src/odi_dev_end.sv */
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Start is SDA falling while SCL high
// - Master sends seven address bits, direction, MSB first
// - SDA changes only while SCL is low
// - Acknowledge only own or broadcast address, whole ninth clock
// - Each further byte: eight bits plus acknowledge
// - Stop releases bus, await start and match
// - Single write is 36 clocks, four bytes
// - Acknowledge every received byte of a write
// - Commit on falling edge after lower byte
// - Command byte selects the target register
// - Address is 1001 plus strap-selected low bits
// - Strap sampled and latched at the start condition
// - Broadcast address 1000 111 also answered
// - Broadcast answered only for writes
// - Codes left-aligned, bits 11 to 2
// - Selects: 01h, 02h, 03h, 08h to 0Fh
// - Load strobe high holds code until low
// - Code 1010 in soft reset field resets
// - Channels start powered down until the power-down word is written
module odi_dev_end
  import odi_pkg::*;
(
  input  wire logic                        CLK,
  input  wire logic                        ARST_N,
  input  wire logic                        CE,
  odi_if.device                            BUS,
  input  wire logic [1:0]                  STRAP_SEL,
  input  wire logic                        LOAD_STROBE,
  output logic      [NUM_CH-1:0][CODE_W-1:0] CHAN_CODE,
  output logic      [NUM_CH-1:0]           CHAN_PDOWN
);

  localparam int IN_W = 5;

  logic [IN_W-1:0] raw;
  logic [IN_W-1:0] s1_q;
  logic [IN_W-1:0] s2_q;
  logic [IN_W-1:0] s3_q;
  logic            scl_f_q;
  logic            sda_f_q;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_evt;
  logic            stop_evt;
  logic            load_strobe_pin_fall;
  odi_dstate_t     state_q;
  logic [3:0]      bit_cnt_q;
  logic [7:0]      shift_q;
  logic [1:0]      byte_q;
  logic [7:0]      cmd_q;
  logic [7:0]      msb_q;
  logic [2:0]      strap_q;
  logic            sda_oe_q;
  logic            commit;
  logic [15:0]     word;
  logic            soft_rst;
  logic            async_q;
  logic [PD_W-1:0] pd_q;
  logic            upd_now;
  logic            addr_hit;

  assign raw = {STRAP_SEL, LOAD_STROBE, BUS.sda, BUS.scl};

  // Two-stage synchronisers; a third stage feeds the deglitch compare and the edge detects
  generate
    for (genvar i = 0; i < IN_W; i++)
    begin : g_sync
      always_ff @(posedge CLK or negedge ARST_N)
      begin
        if (!ARST_N)
        begin
          s1_q[i] <= (i < 2) ? 1'b1 : 1'b0;
          s2_q[i] <= (i < 2) ? 1'b1 : 1'b0;
          s3_q[i] <= (i < 2) ? 1'b1 : 1'b0;
        end
        else if (CE)
        begin
          s1_q[i] <= raw[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
        end
      end
    end
  endgenerate

  // A level must hold two samples before it counts, so one-cycle spikes vanish
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end
    else if (CE)
    begin
      if (s2_q[0] == s3_q[0])
        scl_f_q <= s2_q[0];
      if (s2_q[1] == s3_q[1])
        sda_f_q <= s2_q[1];
    end
  end

  // Bus events from the filtered levels; both lines share the same delay, so order is kept
  assign scl_rise  = !scl_f_q && s2_q[0] && s3_q[0];
  assign scl_fall  = scl_f_q && !s2_q[0] && !s3_q[0];
  assign start_evt = scl_f_q && sda_f_q && !s2_q[1] && !s3_q[1] && s2_q[0];
  assign stop_evt  = scl_f_q && !sda_f_q && s2_q[1] && s3_q[1] && s2_q[0];
  assign load_strobe_pin_fall = s3_q[2] && !s2_q[2];

  // Own address or a broadcast write; a broadcast read is never matched
  assign addr_hit = (shift_q[7:1] == {ADDR_FIXED_HI, strap_q})
                 || (shift_q[7:1] == ADDR_BCAST && shift_q[0] == DIR_WRITE);

  // Serial state machine: receive byte, acknowledge, or sit out until stop
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_q   <= D_IDLE;
      bit_cnt_q <= '0;
      shift_q   <= '0;
      byte_q    <= BYTE_ADDR;
      cmd_q     <= '0;
      msb_q     <= '0;
      strap_q   <= '0;
      sda_oe_q  <= 1'b0;
    end
    else if (CE)
    begin
      if (start_evt)
      begin
        state_q   <= D_RX;
        bit_cnt_q <= '0;
        byte_q    <= BYTE_ADDR;
        strap_q   <= {1'b0, s2_q[4:3]};
        sda_oe_q  <= 1'b0;
      end
      else if (stop_evt)
      begin
        state_q  <= D_IDLE;
        sda_oe_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          D_RX:
          begin
            if (scl_rise && bit_cnt_q != BIT_LAST)
            begin
              shift_q   <= {shift_q[6:0], sda_f_q};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (scl_fall && bit_cnt_q == BIT_LAST)
            begin
              bit_cnt_q <= '0;
              if (byte_q == BYTE_ADDR && !addr_hit)
                state_q <= D_WAIT;
              else
              begin
                state_q  <= D_ACK;
                sda_oe_q <= 1'b1;
              end
              if (byte_q == BYTE_CMD)
                cmd_q <= shift_q;
              if (byte_q == BYTE_MSB)
                msb_q <= shift_q;
            end
          end
          D_ACK:
          begin
            if (scl_fall)
            begin
              sda_oe_q <= 1'b0;
              // Reads are not served: after acknowledging the address the data slots stay released
              state_q  <= (byte_q == BYTE_ADDR && shift_q[0] != DIR_WRITE) ? D_WAIT : D_RX;
              byte_q   <= (byte_q == BYTE_LSB) ? BYTE_MSB : byte_q + 2'h1;
            end
          end
          D_WAIT:
            state_q <= D_WAIT;
          D_IDLE:
            state_q <= D_IDLE;
          default:
            state_q <= D_IDLE;
        endcase
      end
    end
  end

  assign BUS.d_sda_o  = 1'b0;
  assign BUS.d_sda_oe = sda_oe_q;

  // Commit only at the falling edge that closes the acknowledge of the lower byte
  assign commit   = CE && state_q == D_ACK && scl_fall && byte_q == BYTE_LSB && !start_evt && !stop_evt;
  assign word     = {msb_q, shift_q};
  assign soft_rst = commit && cmd_q == SEL_TRIG && word[SRST_MSB:0] == SOFT_RESET_CODE;
  // Outputs move for all pending channels at stop after an async-mode channel write, or on strobe fall
  assign upd_now  = (stop_evt && async_q) || load_strobe_pin_fall;

  // Power-down word and mode flag
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pd_q       <= PD_RESET;
      async_q    <= 1'b0;
      CHAN_PDOWN <= PD_RESET[NUM_CH-1:0];
    end
    else if (CE)
    begin
      if (soft_rst)
        pd_q <= PD_RESET;
      else if (commit && cmd_q == SEL_PDOWN)
        pd_q <= word[PD_W-1:0];
      if (soft_rst || stop_evt)
        async_q <= 1'b0;
      else if (commit && !s2_q[2] && (cmd_q == SEL_ALL || cmd_q[7:3] == SEL_CH_BASE[7:3]))
        async_q <= 1'b1;
      CHAN_PDOWN <= pd_q[NUM_CH-1:0] | {NUM_CH{pd_q[PD_GLOBAL]}};
    end
  end

  // Per channel: buffered code, pending flag and the active code seen outside
  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
      logic [CODE_W-1:0] buf_q;
      logic              dirty_q;
      logic              wr;
      assign wr = commit && (cmd_q == SEL_ALL || cmd_q == SEL_CH_BASE + 8'(c));
      always_ff @(posedge CLK or negedge ARST_N)
      begin
        if (!ARST_N)
        begin
          buf_q        <= '0;
          dirty_q      <= 1'b0;
          CHAN_CODE[c] <= '0;
        end
        else if (CE)
        begin
          if (soft_rst)
          begin
            buf_q        <= '0;
            dirty_q      <= 1'b0;
            CHAN_CODE[c] <= '0;
          end
          else
          begin
            if (upd_now && dirty_q)
            begin
              CHAN_CODE[c] <= buf_q;
              dirty_q      <= 1'b0;
            end
            if (wr)
            begin
              buf_q   <= word[CODE_MSB:CODE_LSB];
              dirty_q <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

endmodule // odi_dev_end
`default_nettype wire

/* File: src/odi_host_end.sv */
`timescale 1ns/1ps
`default_nettype none
module odi_host_end
  import odi_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  odi_if.master            BUS
);

  logic        sda_s1_q;
  logic        sda_s2_q;
  logic [6:0]  saddr_q;
  logic [7:0]  cmd_q;
  logic [15:0] data_q;
  logic        nack_q;
  logic        access;
  logic        go;
  logic        mapped;
  odi_hstate_t state_q;
  logic [3:0]  qcnt_q;
  logic [1:0]  ph_q;
  logic        tick;
  logic [35:0] frame_q;
  logic [5:0]  bit_q;
  logic [3:0]  slot_q;
  logic        scl_oe_q;
  logic        sda_oe_q;

  // Data line comes back from the wire, so it is synchronised before use
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end
    else if (CE)
    begin
      sda_s1_q <= BUS.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  // APB slave: one wait state, write and read data both land on the edge with PREADY high
  assign access = PSEL && PENABLE && PREADY;
  assign go     = access && PWRITE && PADDR == REG_CTRL && PWDATA[CTRL_GO] && state_q == H_IDLE;
  assign mapped = PADDR == REG_CTRL || PADDR == REG_SADDR || PADDR == REG_CMD
               || PADDR == REG_DATA || PADDR == REG_STAT;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
      saddr_q <= '0;
      cmd_q   <= '0;
      data_q  <= '0;
    end
    else if (CE)
    begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
      case (PADDR)
        REG_SADDR: PRDATA <= {25'h0000000, saddr_q};
        REG_CMD:   PRDATA <= {24'h000000, cmd_q};
        REG_DATA:  PRDATA <= {16'h0000, data_q};
        REG_STAT:  PRDATA <= {30'h00000000, nack_q, state_q != H_IDLE};
        default:   PRDATA <= '0;
      endcase
      if (access && PWRITE)
      begin
        if (PADDR == REG_SADDR)
          saddr_q <= PWDATA[6:0];
        if (PADDR == REG_CMD)
          cmd_q <= PWDATA[7:0];
        if (PADDR == REG_DATA)
          data_q <= PWDATA[15:0];
      end
    end
  end

  // Quarter-period timer of the serial clock, free running only while a frame is under way
  assign tick = qcnt_q == QTR_LAST;

  // Frame sequencer: start, up to 36 clocks with released acknowledge slots, stop after the last clock or a refused byte
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_q  <= H_IDLE;
      qcnt_q   <= '0;
      ph_q     <= '0;
      frame_q  <= '0;
      bit_q    <= '0;
      slot_q   <= '0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      nack_q   <= 1'b0;
    end
    else if (CE)
    begin
      qcnt_q <= (state_q == H_IDLE || tick) ? 4'h0 : qcnt_q + 4'h1;
      if (tick)
        ph_q <= ph_q + 2'h1;
      case (state_q)
        H_IDLE:
        begin
          if (go)
          begin
            state_q <= H_START;
            ph_q    <= '0;
            nack_q  <= 1'b0;
            bit_q   <= '0;
            slot_q  <= '0;
            frame_q <= {saddr_q, DIR_WRITE, 1'b1, cmd_q, 1'b1, data_q[15:8], 1'b1, data_q[7:0], 1'b1};
          end
        end
        H_START:
        begin
          if (tick && ph_q == 2'h0)
            sda_oe_q <= 1'b1;
          if (tick && ph_q == 2'h1)
          begin
            scl_oe_q <= 1'b1;
            state_q  <= H_BITS;
            ph_q     <= '0;
          end
        end
        H_BITS:
        begin
          if (tick && ph_q == 2'h0)
            sda_oe_q <= !frame_q[35];
          if (tick && ph_q == 2'h1)
            scl_oe_q <= 1'b0;
          if (tick && ph_q == 2'h3)
          begin
            scl_oe_q <= 1'b1;
            frame_q  <= {frame_q[34:0], 1'b1};
            bit_q    <= bit_q + 6'h01;
            slot_q   <= (slot_q == BIT_LAST) ? 4'h0 : slot_q + 4'h1;
            if ((slot_q == BIT_LAST && sda_s2_q) || bit_q == FRAME_LAST)
            begin
              nack_q  <= slot_q == BIT_LAST && sda_s2_q;
              state_q <= H_STOP;
            end
          end
        end
        H_STOP:
        begin
          if (tick && ph_q == 2'h0)
            sda_oe_q <= 1'b1;
          if (tick && ph_q == 2'h1)
            scl_oe_q <= 1'b0;
          if (tick && ph_q == 2'h2)
            sda_oe_q <= 1'b0;
          if (tick && ph_q == 2'h3)
            state_q <= H_IDLE;
        end
        default:
          state_q <= H_IDLE;
      endcase
    end
  end

  assign BUS.m_scl_o  = 1'b0;
  assign BUS.m_sda_o  = 1'b0;
  assign BUS.m_scl_oe = scl_oe_q;
  assign BUS.m_sda_oe = sda_oe_q;

endmodule // odi_host_end
`default_nettype wire

/* File: src/odi_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface odi_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  wire  scl;
  wire  sda;
  // Open-drain wires with pull-ups: any enabled driver with a low output wins
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !(m_sda_oe && !m_sda_o) && !(d_sda_oe && !d_sda_o);
  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport device (output d_sda_o, d_sda_oe, input scl, sda);
endinterface // odi_if
`default_nettype wire

/* File: src/odi_pkg.sv */
package odi_pkg;
  // Address byte layout
  localparam logic [3:0] ADDR_FIXED_HI = 4'h9;      // Upper four address bits, binary 1001
  localparam logic [6:0] ADDR_BCAST    = 7'h47;     // Broadcast address, 1000 111
  localparam logic       DIR_WRITE     = 1'b0;
  // Serial framing
  localparam logic [3:0] BIT_LAST      = 4'h8;      // Bits per byte before the acknowledge slot
  localparam logic [1:0] BYTE_ADDR     = 2'h0;
  localparam logic [1:0] BYTE_CMD      = 2'h1;
  localparam logic [1:0] BYTE_MSB      = 2'h2;
  localparam logic [1:0] BYTE_LSB      = 2'h3;
  // Register selects carried by the command byte
  localparam logic [7:0] SEL_PDOWN     = 8'h01;
  localparam logic [7:0] SEL_TRIG      = 8'h02;
  localparam logic [7:0] SEL_ALL       = 8'h03;
  localparam logic [7:0] SEL_CH_BASE   = 8'h08;
  localparam int         NUM_CH        = 8;
  // Data word fields
  localparam int         CODE_W        = 10;
  localparam int         CODE_MSB      = 11;
  localparam int         CODE_LSB      = 2;
  localparam int         PD_W          = 9;
  localparam int         PD_GLOBAL     = 8;
  localparam logic [8:0] PD_RESET      = 9'h0ff;    // Every channel starts powered down
  localparam int         SRST_MSB      = 3;
  localparam logic [3:0] SOFT_RESET_CODE = 4'ha;    // Reserved code 1010 in the soft reset field
  // Serial clock made by the bus master
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         SCL_PERIOD_NS = 640;
  localparam int         QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [3:0] QTR_LAST      = 4'(QTR_CYC - 1);
  localparam logic [5:0] FRAME_LAST    = 6'h23;     // 36 clocks per single update
  // Bus master registers on APB (byte addresses)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_SADDR     = 8'h04;
  localparam logic [7:0] REG_CMD       = 8'h08;
  localparam logic [7:0] REG_DATA      = 8'h0c;
  localparam logic [7:0] REG_STAT      = 8'h10;
  localparam int         CTRL_GO       = 0;
  localparam int         STAT_BUSY     = 0;
  localparam int         STAT_NACK     = 1;
  // One-hot state codes
  typedef enum logic [3:0] {D_IDLE = 4'h1, D_RX = 4'h2, D_ACK = 4'h4, D_WAIT = 4'h8} odi_dstate_t;
  typedef enum logic [3:0] {H_IDLE = 4'h1, H_START = 4'h2, H_BITS = 4'h4, H_STOP = 4'h8} odi_hstate_t;
endpackage

/* File: tb/odi_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module odi_assertions
  import odi_pkg::*;
(
  input  wire logic CLK,
  input  wire logic ARST_N,
  input  wire logic m_scl_oe,
  input  wire logic m_sda_oe,
  input  wire logic d_sda_oe,
  input  wire logic scl,
  input  wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       in_frame_q;
  logic [3:0] bit_q;
  logic [5:0] rise_q;
  wire        start_w = scl && scl_q && sda_q && !sda;
  wire        stop_w  = scl && scl_q && !sda_q && sda;
  wire        rise_w  = scl && !scl_q;

  // Last wire levels, so conditions are found without sampled-value calls
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Frame flag; a repeated start leaves it set
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      in_frame_q <= 1'b0;
    else if (start_w || stop_w)
      in_frame_q <= start_w;
  end

  // Slot of the current high phase (4'hf: none yet) and clock rises per frame
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      bit_q  <= 4'hf;
      rise_q <= 6'h00;
    end
    else if (start_w)
    begin
      bit_q  <= 4'hf;
      rise_q <= 6'h00;
    end
    else if (rise_w)
    begin
      bit_q  <= (bit_q == 4'h8 || bit_q == 4'hf) ? 4'h0 : bit_q + 4'h1;
      rise_q <= rise_q + 6'h01;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  // Conditions on the wire; the stop also counts one clock rise of its own
  sequence s_stop;
    scl && $rose(sda);
  endsequence
  sequence s_ack_rise;
    $rose(scl) && d_sda_oe;
  endsequence
  sequence s_ack_fall;
    scl ##1 (!scl && d_sda_oe);
  endsequence

  AST_DEV_SDA_CHANGE_LOW: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device moved SDA while SCL high");
  AST_ACK_WHOLE_HIGH: assert property (s_ack_rise |-> d_sda_oe [*8])
    else $error("acknowledge dropped during SCL high");
  AST_ACK_RELEASE: assert property (s_ack_fall |-> ##[1:8] !d_sda_oe)
    else $error("acknowledge held too long");
  AST_ACK_NINTH: assert property (d_sda_oe && scl && scl_q |-> bit_q == 4'h8)
    else $error("device pulled SDA outside the ninth clock");
  AST_IDLE_RELEASED: assert property (!in_frame_q |-> !d_sda_oe)
    else $error("device pulled SDA outside a frame");
  AST_SCL_IN_FRAME: assert property ($rose(m_scl_oe) |-> in_frame_q)
    else $error("clock driven before a start");
  AST_MASTER_SDA_HOLD: assert property (scl && scl_q && $changed(m_sda_oe) |->
    (!in_frame_q && m_sda_oe) || (in_frame_q && !m_sda_oe && bit_q == 4'h0))
    else $error("master moved SDA while SCL high");
  AST_FRAME_CLOCKS: assert property (s_stop |-> rise_q inside {6'h0a, 6'h13, 6'h1c, 6'h25})
    else $error("frame length not whole bytes");
  cover property (s_stop and (rise_q == 6'h25));
endmodule // odi_assertions
`default_nettype wire

/* File: tb/tb_octal_dac_i2c_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_octal_dac_i2c_slave
  import odi_pkg::*;
;
  logic             clk = 1'b0;
  logic             arst_n = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [1:0]       strap = 2'h0;
  logic             ld_hold = 1'b0;
  logic [7:0][9:0]  code;
  logic [7:0]       pdown;
  logic [9:0]       exp_code [NUM_CH];
  logic [7:0]       exp_pd = 8'hff;
  logic [15:0]      pd_word [3] = '{16'h0005, 16'h0100, 16'h0000};
  logic [7:0]       pd_exp [3] = '{8'h05, 8'hff, 8'h00};
  logic [31:0]      rd;
  logic             slv;
  int               errors = 0;
  int               checked = 0;

  // Both ends face each other; the checker watches the wire between them
  odi_if bus ();
  odi_host_end i_odi_host_end (.CLK(clk), .ARST_N(arst_n), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BUS(bus));
  odi_dev_end i_odi_dev_end (.CLK(clk), .ARST_N(arst_n), .CE(1'b1), .BUS(bus), .STRAP_SEL(strap),
    .LOAD_STROBE(ld_hold), .CHAN_CODE(code), .CHAN_PDOWN(pdown));
  odi_assertions i_odi_assertions (.CLK(clk), .ARST_N(arst_n), .m_scl_oe(bus.m_scl_oe),
    .m_sda_oe(bus.m_sda_oe), .d_sda_oe(bus.d_sda_oe), .scl(bus.scl), .sda(bus.sda));

  // 25 MHz system clock
  always #20 clk = ~clk;

  // Compares for register words and channel outputs
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_out(input logic [9:0] got, input logic [9:0] exp);
    check_reg({22'h0, got}, {22'h0, exp});
  endtask

  // One APB transfer; ready, read data and error are all taken at the rising edge that sees ready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    check_reg({31'h0, pready}, 32'h1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Whole write frame through the host registers, then wait for it to finish
  task automatic frame(input logic [6:0] sa, input logic [7:0] cmd, input logic [15:0] d, input logic nk);
    int n = 0;
    apb(1'b1, REG_SADDR, {25'h0, sa});
    apb(1'b1, REG_CMD, {24'h0, cmd});
    apb(1'b1, REG_DATA, {16'h0, d});
    apb(1'b1, REG_CTRL, 32'h1);
    do
    begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end
    while (rd[STAT_BUSY] !== 1'b0 && n < 400);
    check_reg({31'h0, rd[STAT_BUSY]}, 32'h0);
    check_reg({31'h0, rd[STAT_NACK]}, {31'h0, nk});
    repeat (8) @(posedge clk);
  endtask

  // Every channel code and power-down output against the expected model
  task automatic check_chans;
    for (int c = 0; c < NUM_CH; c++)
      check_out(code[c], exp_code[c]);
    check_reg({24'h0, pdown}, {24'h0, exp_pd});
  endtask

  // Closing verdict
  task automatic results;
    $display("Counts: %0d compares, %0d mismatches", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog: about three times the expected run
  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    results;
  end

  // Test sequence
  initial
  begin
    for (int c = 0; c < NUM_CH; c++)
      exp_code[c] = 10'h000;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    check_chans;
    apb(1'b0, 8'h14, 32'h0);
    check_reg({31'h0, slv}, 32'h1);
    check_reg(rd, 32'h0);
    $display("Test reset done");
    // Every channel select; upper nibble and two low bits must be ignored
    for (int c = 0; c < NUM_CH; c++)
    begin
      frame(7'h48, SEL_CH_BASE + 8'(c), {4'h5, 10'(c * 97 + 5), 2'h3}, 1'b0);
      exp_code[c] = 10'(c * 97 + 5);
      check_chans;
    end
    $display("Test channels done");
    // Each strap connection gives its own address; a stale address is refused
    for (int s = 0; s < 4; s++)
    begin
      strap <= 2'(s);
      frame({ADDR_FIXED_HI, 1'b0, 2'(s)}, SEL_CH_BASE, {4'h0, 10'(s + 1), 2'h0}, 1'b0);
      exp_code[0] = 10'(s + 1);
      check_chans;
    end
    strap <= 2'h1;
    frame(7'h48, SEL_CH_BASE, 16'hfffc, 1'b1);
    check_chans;
    $display("Test address done");
    // Broadcast address with the all-channel register
    strap <= 2'h3;
    frame(ADDR_BCAST, SEL_ALL, 16'h0abc, 1'b0);
    for (int c = 0; c < NUM_CH; c++)
      exp_code[c] = 10'h2af;
    check_chans;
    $display("Test broadcast done");
    // Load strobe high holds the new code until it falls
    ld_hold <= 1'b1;
    frame(7'h4b, SEL_CH_BASE + 8'h01, 16'h0004, 1'b0);
    check_chans;
    ld_hold <= 1'b0;
    repeat (8) @(posedge clk);
    exp_code[1] = 10'h001;
    check_chans;
    $display("Test load strobe done");
    // Power-down word: single channels, global bit, all up
    foreach (pd_word[i])
    begin
      frame(7'h4b, SEL_PDOWN, pd_word[i], 1'b0);
      exp_pd = pd_exp[i];
      check_chans;
    end
    $display("Test power down done");
    // Unknown select writes nothing; soft reset code restores defaults
    frame(7'h4b, 8'h05, 16'hfffc, 1'b0);
    check_chans;
    frame(7'h4b, SEL_TRIG, {12'h000, SOFT_RESET_CODE}, 1'b0);
    for (int c = 0; c < NUM_CH; c++)
      exp_code[c] = 10'h000;
    exp_pd = 8'hff;
    check_chans;
    // Host registers keep what the last frame sent
    apb(1'b0, REG_SADDR, 32'h0);
    check_reg(rd, 32'h0000004b);
    apb(1'b0, REG_CMD, 32'h0);
    check_reg(rd, {24'h000000, SEL_TRIG});
    apb(1'b0, REG_DATA, 32'h0);
    check_reg(rd, {28'h0000000, SOFT_RESET_CODE});
    $display("Test soft reset done");
    results;
  end
endmodule // tb_octal_dac_i2c_slave
`default_nettype wire
